// ### src/ubi_map.svh
`ifndef UBI_MAP_SVH
`define UBI_MAP_SVH
// Register indices on the software port
`define UBI_A_STAT 4'h0
`define UBI_A_ENM 4'h1
`define UBI_A_ENX 4'h2
`define UBI_A_RENB 4'h3
`define UBI_A_NENB 4'h4
`define UBI_A_EENB 4'h5
`define UBI_A_RSTS 4'h6
`define UBI_A_NSTS 4'h7
`define UBI_A_ESTS 4'h8
`define UBI_A_TESEL 4'h9
`define UBI_A_PID 4'ha
`define UBI_A_BUFFER_CLEAR 4'hb
// Bit positions in main status and main enable
`define UBI_B_BUFFER_READY_IRQ 0
`define UBI_B_NOT_READY_IRQ 1
`define UBI_B_BUFFER_EMPTY_IRQ 2
// Bit position of the ready-clear mode in the aux enable
`define UBI_B_MODE 0
// Reset values
`define UBI_RST16 16'h0000
`define UBI_RST8 8'h00
`define UBI_RST3 3'h0
// Transmit side threshold for the empty event, in bytes
`define UBI_TX_SMALL 11'h008
// Packet size zero
`define UBI_MPS_ZERO 11'h000
// One-hot base for pipe decode
`define UBI_ONE8 8'h01
`endif

// ### src/ubi_pkg.sv
`default_nettype none
package ubi_pkg;
	// Pipe number, pipe 0 is the control pipe
	typedef logic [2:0] ubi_pipe_t;
	// Token kinds seen on the bus
	typedef enum logic [1:0] {
		UBI_TOK_IN = 2'b00,
		UBI_TOK_OUT = 2'b01,
		UBI_TOK_PING = 2'b10,
		UBI_TOK_SETUP = 2'b11
	} ubi_tok_e;
	// Pipe response codes
	typedef enum logic [1:0] {
		UBI_PID_NAK = 2'b00,
		UBI_PID_BUF = 2'b01,
		UBI_PID_STALL = 2'b10,
		UBI_PID_STALL2 = 2'b11
	} ubi_pid_e;
endpackage : ubi_pkg
`default_nettype wire

// ### src/ubi_buffer_irq.sv
`include "ubi_map.svh"
`default_nettype none
module ubi_buffer_irq (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// Software register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// Context of the current event
	input wire logic host_mode_in,
	input wire ubi_pkg::ubi_pipe_t ev_pipe_in,
	input wire logic [10:0] max_packet_size_in,
	input wire logic pipe_is_bulk_in,
	input wire logic pipe_is_iso_in,
	// Receive events
	input wire logic rx_done_in,
	input wire logic [10:0] rx_bytes_in,
	input wire logic rx_short_in,
	input wire logic rx_tc_end_in,
	input wire logic continuous_buffer_mode_in,
	input wire logic [10:0] buffer_fill_in,
	input wire logic [10:0] buffer_size_in,
	// Transmit events
	input wire logic tx_ack_in,
	input wire logic tx_sent_in,
	input wire logic double_buffer_in,
	input wire logic [10:0] other_side_bytes_in,
	// Token events
	input wire logic tok_done_in,
	input wire ubi_pkg::ubi_tok_e tok_kind_in,
	input wire logic hs_ack_in,
	input wire logic hs_stall_in,
	input wire logic hs_none_in,
	input wire logic iso_err_in,
	input wire logic out_of_interval_in,
	input wire logic buf_has_data_in,
	input wire logic buf_has_space_in,
	// Buffer status flags per pipe
	input wire logic [7:0] buffer_status_flag_in,
	// Outputs
	output logic irq_out,
	output logic nak_out,
	output logic setup_error_out,
	output logic [7:0] buffer_clear_out,
	output logic [15:0] pipe_response_out
);
	import ubi_pkg::*;

	// Software visible state
	logic [2:0] interrupt_enable_main_q;
	logic ready_clear_mode_q;
	logic [7:0] ready_enb_q, not_ready_enb_q, empty_enb_q;
	logic [7:0] buffer_ready_pipe_status_q, not_ready_pipe_status_q;
	logic [7:0] buffer_empty_pipe_status_q;
	logic [7:0] transfer_end_ready_select_q;
	logic [15:0] pipe_response_q;
	logic [7:0] buffer_clear_q;
	logic ready_sum_q;
	logic irq_q;
	logic [15:0] rdata_q;

	// Address decode
	wire wr_enm = reg_wr_in && (reg_addr_in == `UBI_A_ENM);
	wire wr_enx = reg_wr_in && (reg_addr_in == `UBI_A_ENX);
	wire wr_renb = reg_wr_in && (reg_addr_in == `UBI_A_RENB);
	wire wr_nenb = reg_wr_in && (reg_addr_in == `UBI_A_NENB);
	wire wr_eenb = reg_wr_in && (reg_addr_in == `UBI_A_EENB);
	wire wr_rsts = reg_wr_in && (reg_addr_in == `UBI_A_RSTS);
	wire wr_nsts = reg_wr_in && (reg_addr_in == `UBI_A_NSTS);
	wire wr_ests = reg_wr_in && (reg_addr_in == `UBI_A_ESTS);
	wire wr_tesel = reg_wr_in && (reg_addr_in == `UBI_A_TESEL);
	wire wr_pid = reg_wr_in && (reg_addr_in == `UBI_A_PID);
	wire wr_buffer_clear = reg_wr_in && (reg_addr_in == `UBI_A_BUFFER_CLEAR);

	// One-hot select of the event pipe
	wire [7:0] pipe_sel = `UBI_ONE8 << ev_pipe_in;
	wire non_ctrl = (ev_pipe_in != `UBI_RST3);

	// Response code of the event pipe
	wire [1:0] ev_pid = pipe_response_q[{ev_pipe_in, 1'b0} +: 2];
	wire ev_buf = (ev_pid == UBI_PID_BUF);
	wire mps_zero = (max_packet_size_in == `UBI_MPS_ZERO);

	// Receive classification
	wire rx_zero = (rx_bytes_in == `UBI_MPS_ZERO);
	wire rx_over = rx_bytes_in > max_packet_size_in;
	wire rx_full = continuous_buffer_mode_in ? (buffer_fill_in >= buffer_size_in)
		: (rx_bytes_in == max_packet_size_in);
	wire rx_ok = rx_done_in && !rx_over;
	wire te_sel = transfer_end_ready_select_q[ev_pipe_in] && non_ctrl;
	// Per buffer readiness, zlp included
	wire rx_rdy_buf = rx_zero || rx_short_in || rx_tc_end_in || rx_full;
	// Per transfer readiness, only at transfer end
	wire rx_rdy_end = rx_zero || rx_short_in || rx_tc_end_in;
	wire rx_rdy = rx_ok && (te_sel ? rx_rdy_end : rx_rdy_buf);

	// Ready events from either direction
	wire ready_ev = rx_rdy || tx_ack_in;
	wire [7:0] ready_set = pipe_sel & {8{ready_ev}};

	// Token kinds
	wire k_in = (tok_kind_in == UBI_TOK_IN);
	wire k_out = (tok_kind_in == UBI_TOK_OUT) || (tok_kind_in == UBI_TOK_PING);
	wire k_setup = (tok_kind_in == UBI_TOK_SETUP);

	// Host side not-ready causes
	wire h_tok = tok_done_in && host_mode_in;
	wire h_resp = !k_setup && (hs_stall_in || hs_none_in);
	wire h_iso = pipe_is_iso_in && iso_err_in;
	wire h_not_ready_irq = h_tok && (h_resp || (h_iso && !k_setup));
	// Unacked setup goes to setup error only
	wire h_setup_err = h_tok && k_setup && !hs_ack_in;

	// Peripheral side not-ready causes
	wire p_tok = tok_done_in && !host_mode_in;
	wire p_under = k_in && ev_buf && !buf_has_data_in;
	wire p_over = k_out && ev_buf && !buf_has_space_in;
	wire p_bulk0 = k_out && pipe_is_bulk_in && mps_zero;
	wire p_iso = pipe_is_iso_in && (iso_err_in || out_of_interval_in);
	wire p_not_ready_irq = p_tok && (p_under || p_over || p_bulk0 || p_iso);
	wire [7:0] not_ready_set = pipe_sel & {8{h_not_ready_irq || p_not_ready_irq}};

	// Empty events
	wire tx_empty = tx_sent_in
		&& (!double_buffer_in || (other_side_bytes_in < `UBI_TX_SMALL));
	wire rx_oversize = rx_done_in && rx_over;
	wire [7:0] empty_set = pipe_sel & {8{tx_empty || rx_oversize}};
	// Stall for oversize only when max packet size is nonzero
	wire [7:0] stall_set = pipe_sel & {8{rx_oversize && !mps_zero}};

	// Status next values, write 0 clears, a set wins over the clear
	wire [7:0] rdy_clr = wr_rsts ? ~reg_wdata_in[7:0] : `UBI_RST8;
	wire [7:0] nrd_clr = wr_nsts ? ~reg_wdata_in[7:0] : `UBI_RST8;
	wire [7:0] emp_clr = wr_ests ? ~reg_wdata_in[7:0] : `UBI_RST8;
	wire [7:0] rdy_sts_d = ready_set | (buffer_ready_pipe_status_q & ~rdy_clr);
	wire [7:0] nrd_sts_d = not_ready_set | (not_ready_pipe_status_q & ~nrd_clr);
	wire [7:0] emp_sts_d = empty_set | (buffer_empty_pipe_status_q & ~emp_clr);

	// Summaries
	wire rdy_any = |(buffer_ready_pipe_status_q & ready_enb_q);
	wire buffer_status_flag_any = |(buffer_status_flag_in & ready_enb_q);
	wire rdy_set_en = |(ready_set & ready_enb_q);
	// Mode 1 holds until hardware drains every enabled buffer flag
	wire ready_sum_d = rdy_set_en || (ready_sum_q && buffer_status_flag_any);
	wire buffer_ready_irq = ready_clear_mode_q ? ready_sum_q : rdy_any;
	wire not_ready_irq = |(not_ready_pipe_status_q & not_ready_enb_q);
	wire buffer_empty_irq = |(buffer_empty_pipe_status_q & empty_enb_q);
	wire [2:0] interrupt_status_main = {buffer_empty_irq, not_ready_irq, buffer_ready_irq};
	wire irq_d = |(interrupt_status_main & interrupt_enable_main_q);

	// Response codes per pipe, hardware stall wins over software
	wire [15:0] pid_d;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pid
			assign pid_d[2*gi +: 2] = stall_set[gi] ? UBI_PID_STALL
				: (wr_pid ? reg_wdata_in[2*gi +: 2] : pipe_response_q[2*gi +: 2]);
		end
	endgenerate

	// Read mux, unmapped reads return zero
	logic [15:0] rdata_d;
	always_comb begin
		rdata_d = `UBI_RST16;
		unique case (reg_addr_in)
			`UBI_A_STAT: rdata_d = {13'h0000, interrupt_status_main};
			`UBI_A_ENM: rdata_d = {13'h0000, interrupt_enable_main_q};
			`UBI_A_ENX: rdata_d = {15'h0000, ready_clear_mode_q};
			`UBI_A_RENB: rdata_d = {8'h00, ready_enb_q};
			`UBI_A_NENB: rdata_d = {8'h00, not_ready_enb_q};
			`UBI_A_EENB: rdata_d = {8'h00, empty_enb_q};
			`UBI_A_RSTS: rdata_d = {8'h00, buffer_ready_pipe_status_q};
			`UBI_A_NSTS: rdata_d = {8'h00, not_ready_pipe_status_q};
			`UBI_A_ESTS: rdata_d = {8'h00, buffer_empty_pipe_status_q};
			`UBI_A_TESEL: rdata_d = {8'h00, transfer_end_ready_select_q};
			`UBI_A_PID: rdata_d = pipe_response_q;
			default: rdata_d = `UBI_RST16;
		endcase
	end

	// Configuration registers
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			interrupt_enable_main_q <= `UBI_RST3;
			ready_clear_mode_q <= 1'b0;
			ready_enb_q <= `UBI_RST8;
			not_ready_enb_q <= `UBI_RST8;
			empty_enb_q <= `UBI_RST8;
			transfer_end_ready_select_q <= `UBI_RST8;
		end else begin
			if (wr_enm) interrupt_enable_main_q <= reg_wdata_in[2:0];
			if (wr_enx) ready_clear_mode_q <= reg_wdata_in[`UBI_B_MODE];
			if (wr_renb) ready_enb_q <= reg_wdata_in[7:0];
			if (wr_nenb) not_ready_enb_q <= reg_wdata_in[7:0];
			if (wr_eenb) empty_enb_q <= reg_wdata_in[7:0];
			// Pipe 0 has no per-transfer option
			if (wr_tesel) transfer_end_ready_select_q <= {reg_wdata_in[7:1], 1'b0};
		end
	end

	// Status, response and summary state
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			buffer_ready_pipe_status_q <= `UBI_RST8;
			not_ready_pipe_status_q <= `UBI_RST8;
			buffer_empty_pipe_status_q <= `UBI_RST8;
			pipe_response_q <= `UBI_RST16;
			ready_sum_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			buffer_ready_pipe_status_q <= rdy_sts_d;
			not_ready_pipe_status_q <= nrd_sts_d;
			buffer_empty_pipe_status_q <= emp_sts_d;
			pipe_response_q <= pid_d;
			ready_sum_q <= ready_sum_d;
			irq_q <= irq_d;
		end
	end

	// Read data and buffer clear pulses
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_q <= `UBI_RST16;
			buffer_clear_q <= `UBI_RST8;
		end else begin
			rdata_q <= reg_rd_in ? rdata_d : `UBI_RST16;
			// Clear request per pipe, software orders it after status clear
			buffer_clear_q <= wr_buffer_clear ? reg_wdata_in[7:0] : `UBI_RST8;
		end
	end

	// Outputs
	assign reg_rdata_out = rdata_q;
	assign irq_out = irq_q;
	assign nak_out = p_tok && (p_under || p_over);
	assign setup_error_out = h_setup_err;
	assign buffer_clear_out = buffer_clear_q;
	assign pipe_response_out = pipe_response_q;

	// Checks
	zlp_sets_ready_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		rx_done_in && rx_zero && !rx_over |=> buffer_ready_pipe_status_q[$past(ev_pipe_in)])
		else $error("zero-length packet did not set ready status");

	te_blocks_full_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		te_sel && rx_done_in && !rx_short_in && !rx_tc_end_in && !rx_zero && !tx_ack_in
		&& !buffer_ready_pipe_status_q[ev_pipe_in]
		|=> !buffer_ready_pipe_status_q[$past(ev_pipe_in)])
		else $error("per-transfer pipe signalled ready mid transfer");

	tx_ack_ready_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		tx_ack_in |=> buffer_ready_pipe_status_q[$past(ev_pipe_in)])
		else $error("acknowledged transmit did not set ready status");

	mode0_summary_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		!ready_clear_mode_q && ((buffer_ready_pipe_status_q & ready_enb_q) == 8'h00)
		|-> !interrupt_status_main[`UBI_B_BUFFER_READY_IRQ])
		else $error("ready summary held after enabled bits cleared");

	not_ready_irq_record_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		h_not_ready_irq || p_not_ready_irq |=> not_ready_pipe_status_q[$past(ev_pipe_in)])
		else $error("not-ready request was not recorded");

	setup_no_not_ready_irq_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		h_tok && k_setup |-> !h_not_ready_irq && (setup_error_out == !hs_ack_in))
		else $error("setup without ack handled wrongly");

	underrun_nak_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		p_tok && k_in && ev_buf && !buf_has_data_in |-> nak_out ##1
		not_ready_pipe_status_q[$past(ev_pipe_in)])
		else $error("underrun did not NAK and record not-ready");

	oversize_stall_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		rx_done_in && rx_over && !mps_zero |=> buffer_empty_pipe_status_q[$past(ev_pipe_in)]
		&& (pipe_response_q[{$past(ev_pipe_in), 1'b0} +: 2] == UBI_PID_STALL))
		else $error("oversize packet did not stall the pipe");

	big_other_side_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		tx_sent_in && double_buffer_in && (other_side_bytes_in >= `UBI_TX_SMALL)
		&& !rx_done_in |-> empty_set == 8'h00)
		else $error("empty raised while other side holds eight or more bytes");

	irq_gate_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		irq_out |-> $past(|(interrupt_status_main & interrupt_enable_main_q)))
		else $error("interrupt raised without an enabled summary bit");

	full_sets_ready_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		rx_done_in && !rx_over && !te_sel && rx_full
		|=> buffer_ready_pipe_status_q[$past(ev_pipe_in)])
		else $error("full buffer did not set ready status");

	te_end_ready_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		te_sel && rx_done_in && !rx_over && (rx_short_in || rx_tc_end_in)
		|=> buffer_ready_pipe_status_q[$past(ev_pipe_in)])
		else $error("per-transfer pipe missed the transfer end");

	mode1_release_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		ready_clear_mode_q && !buffer_status_flag_any && !rdy_set_en |=> !ready_sum_q)
		else $error("ready summary held after buffer flags drained");

	overrun_nak_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		p_tok && k_out && ev_buf && !buf_has_space_in |-> nak_out ##1
		not_ready_pipe_status_q[$past(ev_pipe_in)])
		else $error("overrun did not NAK and record not-ready");

	not_ready_irq_summary_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		((not_ready_pipe_status_q & not_ready_enb_q) == 8'h00)
		|-> !interrupt_status_main[`UBI_B_NOT_READY_IRQ])
		else $error("not-ready summary held after status cleared");

	tx_empty_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		tx_sent_in && !double_buffer_in |=> buffer_empty_pipe_status_q[$past(ev_pipe_in)])
		else $error("sent pipe did not record empty");
endmodule : ubi_buffer_irq
`default_nettype wire

// ### verification/ubi_usb_model.sv
`default_nettype none
module ubi_usb_model
	import ubi_pkg::*;
(
	// Clock and the design's answers
	input wire logic mclk_in,
	input wire logic nak_in,
	input wire logic setup_error_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Strobes: rx done, tx ack, tx sent, token done
	logic [3:0] strobe = 4'h0;
	// Pipe context of the current event
	ubi_pipe_t pipe = 3'h0;
	logic [10:0] mps = 11'h040, bytes = 11'h000, fill = 11'h000, size = 11'h040, oth = 11'h000;
	logic bulk = 1'b0, isop = 1'b0, sh = 1'b0, tc = 1'b0, cont = 1'b0, dbl = 1'b0;
	logic ierr = 1'b0, ooi = 1'b0, dat = 1'b1, spc = 1'b1;
	logic [2:0] hs = 3'h0;
	ubi_tok_e kind = UBI_TOK_IN;
	// Answers seen during the strobe
	logic n_q, se_q;
	// Ends a strobe after one edge; released counts turn to noise
	task automatic done();
		@(negedge mclk_in);
		n_q = nak_in;
		se_q = setup_error_in;
		@(posedge mclk_in);
		strobe <= 4'h0;
		bytes <= ~bytes;
		oth <= ~oth;
	endtask : done
	// Received data packet
	task automatic rx(input ubi_pipe_t p, input logic [10:0] b, m, input logic s, t, c,
			input logic [10:0] f, z);
		@(posedge mclk_in);
		strobe <= 4'h1;
		pipe <= p;
		bytes <= b;
		mps <= m;
		sh <= s;
		tc <= t;
		cont <= c;
		fill <= f;
		size <= z;
		done();
	endtask : rx
	// Transmit ack or side sent
	task automatic tx(input ubi_pipe_t p, input logic [3:0] k, input logic d,
			input logic [10:0] o);
		@(posedge mclk_in);
		strobe <= k;
		pipe <= p;
		dbl <= d;
		oth <= o;
		done();
	endtask : tx
	// Token; flags are error, off-interval, data, space, bulk, iso, zero size
	task automatic tok(input ubi_pipe_t p, input ubi_tok_e k, input logic [2:0] h,
			input logic [6:0] f, output logic n, se);
		@(posedge mclk_in);
		strobe <= 4'h8;
		pipe <= p;
		kind <= k;
		hs <= h;
		{ierr, ooi, dat, spc, bulk, isop} <= f[6:1];
		mps <= f[0] ? 11'h000 : 11'h040;
		done();
		n = n_q;
		se = se_q;
	endtask : tok
endmodule : ubi_usb_model
`default_nettype wire

// ### verification/tb_top.sv
`include "ubi_map.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ubi_pkg::*;
	// Bench driven inputs, observed outputs and counters
	logic mclk_in = 1'b0, rstn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic host_mode_in = 1'b0;
	logic [3:0] reg_addr_in = 4'h0;
	logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, pipe_response_out, v;
	logic [7:0] buffer_status_flag_in = 8'h00, buffer_clear_out;
	logic irq_out, nak_out, setup_error_out;
	int mismatches = 0, n_tests = 0, cyc = 0, seed = 32'h2560;
	// Clock
	initial begin
		forever #20 mclk_in = ~mclk_in;
	end
	ubi_usb_model usb (.mclk_in(mclk_in), .nak_in(nak_out), .setup_error_in(setup_error_out));
	ubi_buffer_irq ubi_buffer_irq_inst (
		.ev_pipe_in(usb.pipe), .max_packet_size_in(usb.mps), .pipe_is_bulk_in(usb.bulk),
		.pipe_is_iso_in(usb.isop), .rx_done_in(usb.strobe[0]), .rx_bytes_in(usb.bytes),
		.rx_short_in(usb.sh), .rx_tc_end_in(usb.tc), .continuous_buffer_mode_in(usb.cont),
		.buffer_fill_in(usb.fill), .buffer_size_in(usb.size), .tx_ack_in(usb.strobe[1]),
		.tx_sent_in(usb.strobe[2]), .double_buffer_in(usb.dbl), .other_side_bytes_in(usb.oth),
		.tok_done_in(usb.strobe[3]), .tok_kind_in(usb.kind), .hs_ack_in(usb.hs[0]),
		.hs_stall_in(usb.hs[1]), .hs_none_in(usb.hs[2]), .iso_err_in(usb.ierr),
		.out_of_interval_in(usb.ooi), .buf_has_data_in(usb.dat), .buf_has_space_in(usb.spc),
		.mclk_in(mclk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .host_mode_in(host_mode_in),
		.buffer_status_flag_in(buffer_status_flag_in), .irq_out(irq_out), .nak_out(nak_out),
		.setup_error_out(setup_error_out), .buffer_clear_out(buffer_clear_out),
		.pipe_response_out(pipe_response_out));
	// Register write
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	// Compare a result
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	// Register read, data taken in the cycle after the strobe
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		@(posedge mclk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		@(negedge mclk_in);
		v = reg_rdata_out;
		chk(e, v);
	endtask : rchk
	// Ready expected after a received packet
	function automatic logic rdy_exp(input logic te, s, t, c, input logic [10:0] b, m, f, z);
		return s | t | (b == 11'h000) | (!te & (c ? (f >= z) : (b == m)));
	endfunction : rdy_exp
	// Empty expected after one side is sent
	function automatic logic emp_exp(input logic d, input logic [10:0] o);
		return !d | (o < 11'h008);
	endfunction : emp_exp
	// One token case: status, NAK and setup error, then clear
	task automatic tcase(input logic h, input ubi_tok_e k, input logic [2:0] hs,
			input logic [6:0] f, input logic [2:0] x);
		logic [2:0] p;
		logic n, se;
		p = 3'($random(seed));
		@(posedge mclk_in);
		host_mode_in <= h;
		usb.tok(p, k, hs, f, n, se);
		rchk(`UBI_A_NSTS, {8'h00, 8'(x[2]) << p});
		chk({14'h0000, x[1:0]}, {14'h0000, n, se});
		wr(`UBI_A_NSTS, 16'h0000);
	endtask : tcase
	// Verdict
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out
	// Hang guard
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			close_out();
		end
	end
	// Main sequence
	initial begin
		logic [2:0] p;
		logic [10:0] b;
		logic s, t, c, n, se;
		repeat (5) @(posedge mclk_in);
		rstn_in <= 1'b1;
		for (int a = 0; a < 16; a++) begin
			rchk(4'(a), 16'h0000);
		end
		wr(`UBI_A_ENM, 16'h0007);
		wr(`UBI_A_RENB, 16'h00ff);
		wr(`UBI_A_NENB, 16'h00ff);
		wr(`UBI_A_EENB, 16'h00ff);
		wr(`UBI_A_TESEL, 16'h00ff);
		rchk(`UBI_A_TESEL, 16'h00fe);
		wr(`UBI_A_TESEL, 16'h00f0);
		$display("reset and enables done");
		for (int i = 0; i < 24; i++) begin
			p = 3'($random(seed));
			b = 11'($unsigned($random(seed)) % 65);
			s = (b < 11'h040) && $random(seed) % 2;
			t = 1'($random(seed));
			c = 1'($random(seed));
			usb.rx(p, b, 11'h040, s, t, c, 11'(p), 11'h004);
			rchk(`UBI_A_RSTS, {15'h0000, rdy_exp(p[2], s, t, c, b, 11'h040, 11'(p), 11'h004)} << p);
			wr(`UBI_A_RSTS, 16'h0000);
		end
		usb.rx(3'h2, 11'h000, 11'h040, 1'b1, 1'b0, 1'b0, 11'h000, 11'h040);
		rchk(`UBI_A_RSTS, 16'h0004);
		chk(16'h0001, {15'h0000, irq_out});
		wr(`UBI_A_RSTS, 16'h0000);
		wr(`UBI_A_BUFFER_CLEAR, 16'h0004);
		@(negedge mclk_in);
		chk(16'h0004, {8'h00, buffer_clear_out});
		rchk(`UBI_A_STAT, 16'h0000);
		usb.tx(3'h5, 4'h2, 1'b0, 11'h000);
		rchk(`UBI_A_RSTS, 16'h0020);
		wr(`UBI_A_RSTS, 16'h0000);
		wr(`UBI_A_ENX, 16'h0001);
		@(posedge mclk_in);
		buffer_status_flag_in <= 8'h20;
		usb.tx(3'h5, 4'h2, 1'b0, 11'h000);
		wr(`UBI_A_RSTS, 16'h0000);
		rchk(`UBI_A_STAT, 16'h0001);
		@(posedge mclk_in);
		buffer_status_flag_in <= 8'h00;
		rchk(`UBI_A_STAT, 16'h0000);
		wr(`UBI_A_ENX, 16'h0000);
		$display("ready tests done");
		wr(`UBI_A_ENM, 16'h0005);
		// Pipes still answer NAK here, so an empty buffer is no underrun
		tcase(1'b0, UBI_TOK_IN, 3'h0, 7'h08, 3'h0);
		wr(`UBI_A_PID, 16'h5555);
		tcase(1'b1, UBI_TOK_OUT, 3'h2, 7'h18, 3'h4);
		tcase(1'b1, UBI_TOK_IN, 3'h4, 7'h18, 3'h4);
		tcase(1'b1, UBI_TOK_OUT, 3'h1, 7'h5a, 3'h4);
		tcase(1'b1, UBI_TOK_SETUP, 3'h4, 7'h18, 3'h1);
		tcase(1'b1, UBI_TOK_OUT, 3'h1, 7'h18, 3'h0);
		tcase(1'b0, UBI_TOK_IN, 3'h0, 7'h08, 3'h6);
		tcase(1'b0, UBI_TOK_OUT, 3'h0, 7'h10, 3'h6);
		tcase(1'b0, UBI_TOK_PING, 3'h0, 7'h10, 3'h6);
		tcase(1'b0, UBI_TOK_OUT, 3'h0, 7'h1d, 3'h4);
		tcase(1'b0, UBI_TOK_OUT, 3'h0, 7'h5a, 3'h4);
		tcase(1'b0, UBI_TOK_IN, 3'h0, 7'h3a, 3'h4);
		tcase(1'b0, UBI_TOK_IN, 3'h0, 7'h18, 3'h0);
		usb.tok(3'h1, UBI_TOK_IN, 3'h0, 7'h08, n, se);
		rchk(`UBI_A_STAT, 16'h0002);
		chk(16'h0000, {15'h0000, irq_out});
		wr(`UBI_A_ENM, 16'h0003);
		rchk(`UBI_A_NSTS, 16'h0002);
		chk(16'h0001, {15'h0000, irq_out});
		wr(`UBI_A_NSTS, 16'h0000);
		rchk(`UBI_A_STAT, 16'h0000);
		$display("not-ready tests done");
		for (int i = 0; i < 6; i++) begin
			p = 3'($random(seed));
			b = 11'(i + 5);
			usb.tx(p, 4'h4, i != 5, b);
			rchk(`UBI_A_ESTS, {15'h0000, emp_exp(i != 5, b)} << p);
			wr(`UBI_A_ESTS, 16'h0000);
		end
		usb.rx(3'h6, 11'h041, 11'h040, 1'b0, 1'b0, 1'b0, 11'h000, 11'h040);
		usb.rx(3'h7, 11'h001, 11'h000, 1'b0, 1'b0, 1'b0, 11'h000, 11'h040);
		rchk(`UBI_A_ESTS, 16'h00c0);
		chk(16'h0003, {13'h0000, pipe_response_out[15:13]});
		rchk(`UBI_A_STAT, 16'h0004);
		chk(16'h0000, {15'h0000, irq_out});
		wr(`UBI_A_ESTS, 16'h0000);
		rchk(`UBI_A_STAT, 16'h0000);
		$display("empty tests done");
		close_out();
	end
endmodule : tb_top
`default_nettype wire
